// file: core/sble_edge.sv
// Rising edge detector for a vector of source levels
`timescale 1ns/10ps
module sble_edge #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] prev;
  } sble_edge_state_type;

  sble_edge_state_type st_reg;
  sble_edge_state_type st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.prev = level;
    rise         = level & ~st_reg.prev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// file: core/sble_pkg.sv
// Constants for the serial bus link interrupt event block
package sble_pkg;
  // Register byte offsets
  localparam logic [11:0] HOST_CTRL_SET_OFF  = 12'h050;
  localparam logic [11:0] HOST_CTRL_CLR_OFF  = 12'h054;
  localparam logic [11:0] EVT_SET_OFF        = 12'h080;
  localparam logic [11:0] EVT_CLR_OFF        = 12'h084;
  localparam logic [11:0] MASK_SET_OFF       = 12'h088;
  localparam logic [11:0] MASK_CLR_OFF       = 12'h08c;
  localparam logic [11:0] LINK_CTRL_SET_OFF  = 12'h0e0;
  localparam logic [11:0] LINK_CTRL_CLR_OFF  = 12'h0e4;
  localparam logic [11:0] PHY_CTRL_OFF       = 12'h0ec;
  localparam logic [11:0] CYCLE_TIMER_OFF    = 12'h0f0;

  // Event bit positions
  localparam int SOFTWARE_EVENT_BIT  = 29;
  localparam int LATE_ACK_BIT        = 27;
  localparam int PHY_BYTE_BIT        = 26;
  localparam int OVERLONG_BIT        = 25;
  localparam int FATAL_HALT_BIT      = 24;
  localparam int TIMER_MISMATCH_BIT  = 23;
  localparam logic [31:0] EVT_IMPL_MASK = 32'h2f80_0000;

  // Control field positions
  localparam int LATE_ACK_ENABLE_BIT = 29;
  localparam int TIMING_ROOT_BIT     = 21;
  localparam int PHY_BYTE_LSB        = 16;
  localparam int SECONDS_MSB         = 31;
  localparam int SECONDS_LSB         = 25;
  localparam int COUNT_MSB           = 24;
  localparam int COUNT_LSB           = 12;

  // Reset values
  localparam logic [31:0] EVT_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OVERLONG_NS   = 125000;
  localparam logic [11:0] OVERLONG_CYC = 12'(OVERLONG_NS / CLK_PERIOD_NS);

  // Source vector layout
  localparam int NUM_CTX  = 4;
  localparam int SRC_W    = 5 + NUM_CTX;
  localparam int SRC_LATE = 0;
  localparam int SRC_PHY  = 1;
  localparam int SRC_TXCS = 2;
  localparam int SRC_GAP  = 3;
  localparam int SRC_RXCS = 4;
  localparam int SRC_DEAD = 5;
endpackage

// file: core/sble_top.sv
// Interrupt event latch with APB register access
`timescale 1ns/10ps
// How it works
// - Source edge or set write sets bit
// - Only clear-port ones clear a bit
// - Reads return events ANDed with mask
// - Bits 31 and 30 read zero
// - Bit 28 reads zero
// - Bit 29 is software-only event
// - Late-ack event needs its enable set
// - Late-ack from fifo, responder busy, tardy ack
// - PHY byte arrival sets event, byte readable
// - Overlong period over 125 us when root
// - Overlong event clears timing root enable
// - Subunit halt sets fatal event
// - Fatal bit blocks culprit context interrupts
// - Received timer fields mismatch sets event
module sble_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_fifo_host_data,
  input  wire logic        phys_resp_busy,
  input  wire logic        tardy_ack_sent,
  input  wire logic        phy_byte_valid,
  input  wire logic [7:0]  phy_byte_data,
  input  wire logic        cycle_start_tx_begin,
  input  wire logic        subaction_gap_end,
  input  wire logic        cycle_start_rx,
  input  wire logic [6:0]  rx_timer_seconds_field,
  input  wire logic [12:0] rx_timer_count_field,
  input  wire logic [31:0] local_cycle_timer,
  input  wire logic [3:0]  context_dead,
  output logic             timing_root_enable,
  output logic             late_ack_event_enable,
  output logic      [3:0]  context_irq_block
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] evt;
    logic [31:0] mask;
    logic        root_en;
    logic        late_en;
    logic [7:0]  phy_byte;
    logic [3:0]  culprit;
    logic [3:0]  blk;
    logic        run;
    logic [11:0] cnt;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } sble_state_type;

  sble_state_type st_reg;
  sble_state_type st_next;

  logic [sble_pkg::SRC_W-1:0] src_level;
  logic [sble_pkg::SRC_W-1:0] src_rise;
  logic                       setup;
  logic                       access;
  logic                       wr_acc;
  logic                       late_cond;
  logic                       mismatch;
  logic                       overlong;
  logic [31:0]                hw_set;
  logic [31:0]                sw_set;
  logic [31:0]                sw_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Source edges

  assign late_cond = st_reg.late_en & (rx_fifo_host_data | phys_resp_busy | tardy_ack_sent);

  assign src_level = {context_dead, cycle_start_rx, subaction_gap_end,
                      cycle_start_tx_begin, phy_byte_valid, late_cond};

  sble_edge #(
    .W (sble_pkg::SRC_W)
  ) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (src_level),
    .rise    (src_rise)
  );

  assign mismatch =
    (rx_timer_seconds_field != local_cycle_timer[sble_pkg::SECONDS_MSB:sble_pkg::SECONDS_LSB]) ||
    (rx_timer_count_field != local_cycle_timer[sble_pkg::COUNT_MSB:sble_pkg::COUNT_LSB]);

  assign overlong = st_reg.run && st_reg.root_en && (st_reg.cnt == sble_pkg::OVERLONG_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign setup  = psel & ~penable;
  assign access = psel & penable & st_reg.ready;
  assign wr_acc = access & pwrite;

  // Zero bits leave events as they are
  assign sw_set = (wr_acc && paddr == sble_pkg::EVT_SET_OFF) ? (pwdata & sble_pkg::EVT_IMPL_MASK) : '0;
  assign sw_clr = (wr_acc && paddr == sble_pkg::EVT_CLR_OFF) ? (pwdata & sble_pkg::EVT_IMPL_MASK) : '0;

  always_comb begin
    hw_set = '0;
    hw_set[sble_pkg::LATE_ACK_BIT]       = src_rise[sble_pkg::SRC_LATE];
    hw_set[sble_pkg::PHY_BYTE_BIT]       = src_rise[sble_pkg::SRC_PHY];
    hw_set[sble_pkg::OVERLONG_BIT]       = overlong;
    hw_set[sble_pkg::FATAL_HALT_BIT]     = |src_rise[sble_pkg::SRC_DEAD +: sble_pkg::NUM_CTX];
    hw_set[sble_pkg::TIMER_MISMATCH_BIT] = src_rise[sble_pkg::SRC_RXCS] & mismatch;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;

    // Hardware set wins over a clear in the same cycle
    st_next.evt = ((st_reg.evt & ~sw_clr) | sw_set | hw_set) & sble_pkg::EVT_IMPL_MASK;

    if (src_rise[sble_pkg::SRC_PHY]) begin
      st_next.phy_byte = phy_byte_data;
    end

    // Period timer from cycle start send to gap end
    if (src_rise[sble_pkg::SRC_TXCS]) begin
      st_next.run = 1'b1;
      st_next.cnt = '0;
    end else if (src_rise[sble_pkg::SRC_GAP] || overlong) begin
      st_next.run = 1'b0;
    end else if (st_reg.run) begin
      st_next.cnt = st_reg.cnt + 12'h001;
    end

    if (wr_acc) begin
      case (paddr)
        sble_pkg::MASK_SET_OFF: begin
          st_next.mask = st_reg.mask | pwdata;
        end
        sble_pkg::MASK_CLR_OFF: begin
          st_next.mask = st_reg.mask & ~pwdata;
        end
        sble_pkg::HOST_CTRL_SET_OFF: begin
          if (pwdata[sble_pkg::LATE_ACK_ENABLE_BIT]) begin
            st_next.late_en = 1'b1;
          end
        end
        sble_pkg::HOST_CTRL_CLR_OFF: begin
          if (pwdata[sble_pkg::LATE_ACK_ENABLE_BIT]) begin
            st_next.late_en = 1'b0;
          end
        end
        sble_pkg::LINK_CTRL_SET_OFF: begin
          if (pwdata[sble_pkg::TIMING_ROOT_BIT]) begin
            st_next.root_en = 1'b1;
          end
        end
        sble_pkg::LINK_CTRL_CLR_OFF: begin
          if (pwdata[sble_pkg::TIMING_ROOT_BIT]) begin
            st_next.root_en = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (overlong) begin
      st_next.root_en = 1'b0;
    end

    // Culprit contexts stay blocked while the fatal bit stands
    if (!st_next.evt[sble_pkg::FATAL_HALT_BIT]) begin
      st_next.culprit = '0;
    end else begin
      st_next.culprit = st_reg.culprit | src_rise[sble_pkg::SRC_DEAD +: sble_pkg::NUM_CTX];
    end
    st_next.blk = st_next.culprit;

    // Answer prepared in setup, shown in the single access cycle
    st_next.ready = setup;
    st_next.err   = 1'b0;
    st_next.rdata = '0;
    if (setup) begin
      case (paddr)
        sble_pkg::EVT_SET_OFF, sble_pkg::EVT_CLR_OFF: begin
          st_next.rdata = st_reg.evt & st_reg.mask & sble_pkg::EVT_IMPL_MASK;
        end
        sble_pkg::MASK_SET_OFF, sble_pkg::MASK_CLR_OFF: begin
          st_next.rdata = st_reg.mask;
        end
        sble_pkg::HOST_CTRL_SET_OFF, sble_pkg::HOST_CTRL_CLR_OFF: begin
          st_next.rdata[sble_pkg::LATE_ACK_ENABLE_BIT] = st_reg.late_en;
        end
        sble_pkg::LINK_CTRL_SET_OFF, sble_pkg::LINK_CTRL_CLR_OFF: begin
          st_next.rdata[sble_pkg::TIMING_ROOT_BIT] = st_reg.root_en;
        end
        sble_pkg::PHY_CTRL_OFF: begin
          st_next.rdata[sble_pkg::PHY_BYTE_LSB +: 8] = st_reg.phy_byte;
        end
        sble_pkg::CYCLE_TIMER_OFF: begin
          st_next.rdata = local_cycle_timer;
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= '0;
      st_reg.evt  <= sble_pkg::EVT_RESET;
      st_reg.mask <= sble_pkg::MASK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata                = st_reg.rdata;
  assign pready                = st_reg.ready;
  assign pslverr               = st_reg.err;
  assign timing_root_enable    = st_reg.root_en;
  assign late_ack_event_enable = st_reg.late_en;
  assign context_irq_block     = st_reg.blk;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sw_set_evt: assert property (
    wr_acc && paddr == sble_pkg::EVT_SET_OFF && pwdata[sble_pkg::SOFTWARE_EVENT_BIT]
    |=> st_reg.evt[sble_pkg::SOFTWARE_EVENT_BIT])
    else $error("software event not set");

  a_soft_only: assert property (
    $rose(st_reg.evt[sble_pkg::SOFTWARE_EVENT_BIT])
    |-> $past(wr_acc && paddr == sble_pkg::EVT_SET_OFF && pwdata[sble_pkg::SOFTWARE_EVENT_BIT]))
    else $error("software event set by hardware");

  a_clear_evt: assert property (
    wr_acc && paddr == sble_pkg::EVT_CLR_OFF && pwdata[sble_pkg::SOFTWARE_EVENT_BIT]
    |=> !st_reg.evt[sble_pkg::SOFTWARE_EVENT_BIT])
    else $error("software event not cleared");

  a_evt_hold: assert property (
    $fell(st_reg.evt[sble_pkg::TIMER_MISMATCH_BIT])
    |-> $past(wr_acc && paddr == sble_pkg::EVT_CLR_OFF && pwdata[sble_pkg::TIMER_MISMATCH_BIT]))
    else $error("event fell without clear write");

  a_zero_keep: assert property (
    wr_acc && paddr == sble_pkg::EVT_CLR_OFF && !pwdata[sble_pkg::PHY_BYTE_BIT]
    && st_reg.evt[sble_pkg::PHY_BYTE_BIT] |=> st_reg.evt[sble_pkg::PHY_BYTE_BIT])
    else $error("zero clear bit dropped event");

  a_read_and: assert property (
    setup && !pwrite && paddr == sble_pkg::EVT_SET_OFF
    |=> prdata == $past(st_reg.evt & st_reg.mask))
    else $error("event read not masked");

  a_read_and_clr: assert property (
    setup && !pwrite && paddr == sble_pkg::EVT_CLR_OFF
    |=> prdata == $past(st_reg.evt & st_reg.mask))
    else $error("clear port read not masked");

  a_resvd_high: assert property (
    prdata[31:30] == 2'b00 || !pready || $past(paddr) != sble_pkg::EVT_SET_OFF)
    else $error("reserved high bits read nonzero");

  a_resvd_28: assert property (st_reg.evt[28] == 1'b0)
    else $error("reserved bit 28 set");

  a_late_gate: assert property (
    $rose(st_reg.evt[sble_pkg::LATE_ACK_BIT]) && !$past(wr_acc && paddr == sble_pkg::EVT_SET_OFF)
    |-> $past(st_reg.late_en, 2))
    else $error("late ack event without enable");

  a_late_edge: assert property (
    src_rise[sble_pkg::SRC_LATE] |=> st_reg.evt[sble_pkg::LATE_ACK_BIT])
    else $error("late ack condition not flagged");

  a_phy_byte: assert property (
    src_rise[sble_pkg::SRC_PHY]
    |=> st_reg.evt[sble_pkg::PHY_BYTE_BIT] && st_reg.phy_byte == $past(phy_byte_data))
    else $error("phy byte event or data missing");

  a_phy_keep: assert property (!src_rise[sble_pkg::SRC_PHY] |=> $stable(st_reg.phy_byte))
    else $error("phy byte changed without arrival");

  a_overlong_root: assert property (
    overlong |=> st_reg.evt[sble_pkg::OVERLONG_BIT] && !timing_root_enable)
    else $error("overlong not flagged or root kept");

  a_overlong_gate: assert property (
    $rose(st_reg.evt[sble_pkg::OVERLONG_BIT]) && !$past(wr_acc && paddr == sble_pkg::EVT_SET_OFF)
    |-> $past(st_reg.root_en))
    else $error("overlong event without root enable");

  a_root_clear: assert property (
    $fell(timing_root_enable)
    |-> $past(overlong || (wr_acc && paddr == sble_pkg::LINK_CTRL_CLR_OFF && pwdata[sble_pkg::TIMING_ROOT_BIT])))
    else $error("root enable dropped without cause");

  a_fatal_block: assert property (
    |src_rise[sble_pkg::SRC_DEAD +: sble_pkg::NUM_CTX]
    |=> st_reg.evt[sble_pkg::FATAL_HALT_BIT]
        && (context_irq_block & $past(src_rise[sble_pkg::SRC_DEAD +: sble_pkg::NUM_CTX]))
           == $past(src_rise[sble_pkg::SRC_DEAD +: sble_pkg::NUM_CTX]))
    else $error("halt not flagged or context not blocked");

  a_block_fatal: assert property (context_irq_block != 4'h0 |-> st_reg.evt[sble_pkg::FATAL_HALT_BIT])
    else $error("context blocked without fatal event");

  a_mismatch_evt: assert property (
    src_rise[sble_pkg::SRC_RXCS] && mismatch |=> st_reg.evt[sble_pkg::TIMER_MISMATCH_BIT])
    else $error("timer mismatch not flagged");

  a_mismatch_none: assert property (
    src_rise[sble_pkg::SRC_RXCS] && !mismatch && !st_reg.evt[sble_pkg::TIMER_MISMATCH_BIT]
    && !(wr_acc && paddr == sble_pkg::EVT_SET_OFF)
    |=> !st_reg.evt[sble_pkg::TIMER_MISMATCH_BIT])
    else $error("timer match flagged as mismatch");

  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");

  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");

  a_err_pulse: assert property (pslverr |-> pready)
    else $error("error without ready");

endmodule

// file: tb/sble_bench.sv
// Self-checking bench for the serial bus link interrupt event block
`timescale 1ns/10ps
module serial_bus_link_interrupt_events_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_fifo_host_data;
  logic        phys_resp_busy;
  logic        tardy_ack_sent;
  logic        phy_byte_valid;
  logic [7:0]  phy_byte_data;
  logic        cycle_start_tx_begin;
  logic        subaction_gap_end;
  logic        cycle_start_rx;
  logic [6:0]  rx_timer_seconds_field;
  logic [12:0] rx_timer_count_field;
  logic [31:0] local_cycle_timer;
  logic [3:0]  context_dead;
  logic        timing_root_enable;
  logic        late_ack_event_enable;
  logic [3:0]  context_irq_block;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count;
  int          compares;

  sble_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_fifo_host_data(rx_fifo_host_data), .phys_resp_busy(phys_resp_busy),
    .tardy_ack_sent(tardy_ack_sent), .phy_byte_valid(phy_byte_valid), .phy_byte_data(phy_byte_data),
    .cycle_start_tx_begin(cycle_start_tx_begin), .subaction_gap_end(subaction_gap_end),
    .cycle_start_rx(cycle_start_rx), .rx_timer_seconds_field(rx_timer_seconds_field),
    .rx_timer_count_field(rx_timer_count_field), .local_cycle_timer(local_cycle_timer),
    .context_dead(context_dead), .timing_root_enable(timing_root_enable),
    .late_ack_event_enable(late_ack_event_enable), .context_irq_block(context_irq_block));

  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("ERROR at %0t: no pready", $time);
      end_of_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_setclr();
    rd(sble_pkg::EVT_SET_OFF, 32'h0000_0000);
    wr(sble_pkg::MASK_SET_OFF, 32'hffff_ffff);
    wr(sble_pkg::EVT_SET_OFF, 32'hffff_ffff);
    rd(sble_pkg::EVT_SET_OFF, 32'h2f80_0000);
    wr(sble_pkg::EVT_CLR_OFF, 32'h2000_0000);
    rd(sble_pkg::EVT_CLR_OFF, 32'h0f80_0000);
    wr(sble_pkg::MASK_CLR_OFF, 32'h0880_0000);
    rd(sble_pkg::EVT_SET_OFF, 32'h0700_0000);
    wr(sble_pkg::MASK_SET_OFF, 32'h0880_0000);
    rd(sble_pkg::EVT_SET_OFF, 32'h0f80_0000);
    wr(sble_pkg::EVT_SET_OFF, 32'h2000_0000);
    rd(sble_pkg::EVT_SET_OFF, 32'h2f80_0000);
    wr(sble_pkg::EVT_CLR_OFF, 32'hffff_ffff);
    rd(sble_pkg::EVT_SET_OFF, 32'h0000_0000);
  endtask

  task automatic t_late();
    @(posedge pclk);
    rx_fifo_host_data <= 1'b1;
    wt(4);
    rd(sble_pkg::EVT_SET_OFF, 32'h0000_0000);
    rx_fifo_host_data <= 1'b0;
    wr(sble_pkg::HOST_CTRL_SET_OFF, 32'h2000_0000);
    @(posedge pclk);
    chk({31'h0, late_ack_event_enable}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      {tardy_ack_sent, phys_resp_busy, rx_fifo_host_data} <= 3'(1 << i);
      wt(4);
      {tardy_ack_sent, phys_resp_busy, rx_fifo_host_data} <= 3'b000;
      rd(sble_pkg::EVT_SET_OFF, 32'h0800_0000);
      wr(sble_pkg::EVT_CLR_OFF, 32'h0800_0000);
    end
    wr(sble_pkg::HOST_CTRL_CLR_OFF, 32'h2000_0000);
  endtask

  task automatic t_phy();
    @(posedge pclk);
    phy_byte_data  <= 8'h5a;
    phy_byte_valid <= 1'b1;
    wt(3);
    phy_byte_valid <= 1'b0;
    rd(sble_pkg::EVT_SET_OFF, 32'h0400_0000);
    apb(1'b0, sble_pkg::PHY_CTRL_OFF, 32'h0000_0000);
    chk({24'h0, rdat[23:16]}, 32'h0000_005a);
    wr(sble_pkg::EVT_CLR_OFF, 32'h0400_0000);
  endtask

  task automatic t_overlong(input logic root, input logic gap, input logic [31:0] exp);
    if (root)
      wr(sble_pkg::LINK_CTRL_SET_OFF, 32'h0020_0000);
    @(posedge pclk);
    cycle_start_tx_begin <= 1'b1;
    wt(100);
    subaction_gap_end <= gap;
    wt(1100);
    rd(sble_pkg::EVT_SET_OFF, 32'h0000_0000);
    wt(60);
    rd(sble_pkg::EVT_SET_OFF, exp);
    chk({31'h0, timing_root_enable}, {31'h0, root & gap});
    cycle_start_tx_begin <= 1'b0;
    subaction_gap_end    <= 1'b0;
    wr(sble_pkg::EVT_CLR_OFF, 32'h0200_0000);
    wr(sble_pkg::LINK_CTRL_CLR_OFF, 32'h0020_0000);
  endtask

  task automatic t_fatal();
    @(posedge pclk);
    context_dead <= 4'b0100;
    wt(3);
    chk({28'h0, context_irq_block}, 32'h0000_0004);
    rd(sble_pkg::EVT_SET_OFF, 32'h0100_0000);
    wr(sble_pkg::EVT_CLR_OFF, 32'h0100_0000);
    wt(2);
    chk({28'h0, context_irq_block}, 32'h0000_0000);
    context_dead <= 4'b0000;
  endtask

  task automatic t_mismatch(input logic [6:0] ds, input logic [12:0] dc, input logic [31:0] exp);
    @(posedge pclk);
    local_cycle_timer      <= 32'h2abc_d000;
    rx_timer_seconds_field <= 7'h15 ^ ds;
    rx_timer_count_field   <= 13'h0bcd ^ dc;
    wt(2);
    cycle_start_rx <= 1'b1;
    wt(3);
    cycle_start_rx <= 1'b0;
    rd(sble_pkg::EVT_SET_OFF, exp);
    wr(sble_pkg::EVT_CLR_OFF, 32'h0080_0000);
  endtask

  task automatic t_unmapped();
    rd(12'h100, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h1);
    wr(12'h0fc, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h1);
    rd(sble_pkg::EVT_CLR_OFF, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0);
    rd(sble_pkg::MASK_CLR_OFF, 32'hffff_ffff);
    rd(sble_pkg::HOST_CTRL_CLR_OFF, 32'h0000_0000);
    rd(sble_pkg::LINK_CTRL_CLR_OFF, 32'h0000_0000);
    rd(sble_pkg::PHY_CTRL_OFF, 32'h005a_0000);
    wr(sble_pkg::CYCLE_TIMER_OFF, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h0);
    rd(sble_pkg::CYCLE_TIMER_OFF, 32'h2abc_d000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_fifo_host_data, phys_resp_busy, tardy_ack_sent, phy_byte_valid, phy_byte_data} = '0;
    {cycle_start_tx_begin, subaction_gap_end, cycle_start_rx, context_dead} = '0;
    {rx_timer_seconds_field, rx_timer_count_field, local_cycle_timer} = '0;
    err_count = 0;
    compares  = 0;
    wt(16);
    presetn <= 1'b1;
    t_setclr();
    t_late();
    t_phy();
    t_overlong(1'b1, 1'b0, 32'h0200_0000);
    t_overlong(1'b0, 1'b0, 32'h0000_0000);
    t_overlong(1'b1, 1'b1, 32'h0000_0000);
    t_fatal();
    t_mismatch(7'h00, 13'h0000, 32'h0000_0000);
    t_mismatch(7'h00, 13'h0001, 32'h0080_0000);
    t_mismatch(7'h40, 13'h0000, 32'h0080_0000);
    t_unmapped();
    end_of_test();
  end
endmodule
